// ==== capture_edge_unit.sv ====
// Edge selection and rising-edge prescaler for one capture input.
// Assumes the pin arrives already synchronised as its last two sampled stages.
`timescale 1ns/1ps
`default_nettype none
module capture_edge_unit
  import timer_capture_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  capture_mode_if.unit cap
);

  typedef struct packed {
    logic [3:0] count;
    logic event_pulse;
  } unit_state_s;

  unit_state_s st_q;
  unit_state_s st_d;
  logic rise;
  logic fall;
  logic [3:0] last;

  always_comb
  begin
    st_d = st_q;
    rise = cap.pin_mid & ~cap.pin_last;
    fall = ~cap.pin_mid & cap.pin_last;
    last = (cap.mode == CAP_RISING_16) ? PRESCALE_16_LAST : PRESCALE_4_LAST;
    st_d.event_pulse = 1'b0;
    case (cap.mode)
      CAP_FALLING:
      begin
        st_d.count = '0;
        st_d.event_pulse = fall;
      end
      CAP_RISING:
      begin
        st_d.count = '0;
        st_d.event_pulse = rise;
      end
      default:
      begin
        if (rise)
        begin
          // The count restarts from zero on a hit so every Nth edge fires, not the first.
          if (st_q.count >= last)
          begin
            st_d.count = '0;
            st_d.event_pulse = 1'b1;
          end
          else
          begin
            st_d.count = st_q.count + 4'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign cap.event_pulse = st_q.event_pulse;

endmodule
`default_nettype wire

// ==== capture_mode_if.sv ====
// Carrier between the configuration block and one capture edge unit.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface capture_mode_if;
  logic [1:0] mode;
  logic pin_mid;
  logic pin_last;
  logic event_pulse;
  modport ctrl (output mode, output pin_mid, output pin_last, input event_pulse);
  modport unit (input mode, input pin_mid, input pin_last, output event_pulse);
endinterface
`default_nettype wire

// ==== pin_source_model.sv ====
// Model of the external clock and capture pin drivers.
// Assumes pull-ups hold the pins high between bursts of low pulses.
`timescale 1ns/1ps
`default_nettype none
module pin_source_model (
  input wire logic clk_sys_in,
  input wire logic [3:0] go_in,
  input wire logic [7:0] count_in,
  input wire logic [7:0] half_in,
  output logic [3:0] pins_out
);
  logic [7:0] left_q [4] = '{default: 8'h00};
  logic [8:0] phase_q [4] = '{default: 9'h000};
  initial pins_out = 4'hf;
  // The half period is an input so one bench can drive both prompt and slow edges.
  always @(posedge clk_sys_in)
    for (int i = 0; i < 4; i++)
    begin
      pins_out[i] <= !(left_q[i] != 8'h00 && phase_q[i] < {1'b0, half_in});
      if (go_in[i])
      begin
        left_q[i] <= count_in;
        phase_q[i] <= 9'h000;
      end
      else if (left_q[i] != 8'h00)
      begin
        phase_q[i] <= phase_q[i] + 9'h001;
        if (phase_q[i] == {half_in, 1'b0} - 9'h001)
        begin
          left_q[i] <= left_q[i] - 8'h01;
          phase_q[i] <= 9'h000;
        end
      end
    end
endmodule
`default_nettype wire

// ==== timer_capture_config_control.sv ====
// Timer and capture configuration register with clock-source and capture event logic.
// Assumes external pins are asynchronous and the counting datapath lives outside.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_config_control
  import timer_capture_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic shared_timer_ext_clock_pin_in,
  input wire logic third_timer_ext_clock_pin_in,
  input wire logic first_capture_pin_in,
  input wire logic second_capture_pin_in,
  input wire logic first_timer_carry_in,
  input wire logic [TIMER_W-1:0] third_timer_count_in,
  output logic first_timer_tick_out,
  output logic second_timer_tick_out,
  output logic third_timer_tick_out,
  output logic timer_pair_cascade_out,
  output logic first_capture_event_out,
  output logic second_capture_event_out,
  output logic [TIMER_W-1:0] first_capture_value_out,
  output logic [TIMER_W-1:0] second_capture_value_out
);

  typedef struct packed {
    logic [DATA_W-1:0] cfg;
    logic [DATA_W-1:0] rdata;
    logic [PIN_COUNT-1:0][2:0] sync;
    logic [1:0] div;
    logic first_tick;
    logic second_tick;
    logic third_tick;
    logic cascade;
    logic [1:0] cap_event;
    logic [1:0][TIMER_W-1:0] cap_value;
  } ctrl_state_s;

  ctrl_state_s st_q;
  ctrl_state_s st_d;
  logic [PIN_COUNT-1:0] pin_raw;
  logic [1:0] cap_hit;
  logic instr_tick;
  logic shared_fall;
  logic third_fall;
  logic first_src;

  // A fall counts once the low level reaches the second stage while the third still holds the high level.
  function automatic logic falling_seen(input logic [2:0] stages);
    falling_seen = ~stages[SYNC_MID] & stages[SYNC_LAST];
  endfunction

  function automatic logic pick_source(input logic use_pin, input logic pin_fall,
                                       input logic internal);
    pick_source = use_pin ? pin_fall : internal;
  endfunction

  assign pin_raw = {second_capture_pin_in, first_capture_pin_in,
                    third_timer_ext_clock_pin_in, shared_timer_ext_clock_pin_in};

  capture_mode_if cap_if[2] ();

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_cap
      assign cap_if[gi].mode = st_q.cfg[FIRST_CAP_MODE_LSB + 2*gi +: 2];
      assign cap_if[gi].pin_mid = st_q.sync[PIN_CAP_BASE + gi][SYNC_MID];
      assign cap_if[gi].pin_last = st_q.sync[PIN_CAP_BASE + gi][SYNC_LAST];
      assign cap_hit[gi] = cap_if[gi].event_pulse;
      capture_edge_unit u_edge (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .cap(cap_if[gi])
      );
    end
  endgenerate

  always_comb
  begin
    st_d = st_q;
    for (int p = 0; p < PIN_COUNT; p++)
    begin
      st_d.sync[p] = {st_q.sync[p][SYNC_MID], st_q.sync[p][0], pin_raw[p]};
    end

    // The instruction clock is the system clock divided by four, as an enable pulse.
    instr_tick = (st_q.div == INSTR_DIV_LAST);
    st_d.div = instr_tick ? 2'h0 : st_q.div + 2'h1;
    shared_fall = falling_seen(st_q.sync[PIN_SHARED]);
    third_fall = falling_seen(st_q.sync[PIN_THIRD]);

    first_src = pick_source(st_q.cfg[FIRST_SRC_BIT], shared_fall, instr_tick);
    st_d.first_tick = first_src;
    st_d.cascade = st_q.cfg[CASCADE_BIT];
    if (st_q.cfg[CASCADE_BIT])
    begin
      // Upper byte steps only on the lower byte's carry, in a cycle when the lower byte's source ticks too.
      st_d.second_tick = first_src & first_timer_carry_in;
    end
    else
    begin
      st_d.second_tick = pick_source(st_q.cfg[SECOND_SRC_BIT], shared_fall,
                                     instr_tick);
    end
    st_d.third_tick = pick_source(st_q.cfg[THIRD_SRC_BIT], third_fall, instr_tick);

    st_d.cap_event = cap_hit;
    for (int c = 0; c < 2; c++)
    begin
      if (cap_hit[c])
      begin
        st_d.cap_value[c] = third_timer_count_in;
      end
    end

    st_d.rdata = READ_ZERO;
    if (reg_rd_in && (reg_addr_in == CFG_ADDR))
    begin
      st_d.rdata = st_q.cfg;
    end
    if (reg_wr_in && (reg_addr_in == CFG_ADDR))
    begin
      st_d.cfg = reg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      st_q <= '0;
      st_q.cfg <= CFG_RESET;
      // Pins idle high behind pull-ups, so high stages avoid a false edge after reset.
      st_q.sync <= '1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_out = st_q.rdata;
  assign first_timer_tick_out = st_q.first_tick;
  assign second_timer_tick_out = st_q.second_tick;
  assign third_timer_tick_out = st_q.third_tick;
  assign timer_pair_cascade_out = st_q.cascade;
  assign first_capture_event_out = st_q.cap_event[0];
  assign second_capture_event_out = st_q.cap_event[1];
  assign first_capture_value_out = st_q.cap_value[0];
  assign second_capture_value_out = st_q.cap_value[1];

endmodule
`default_nettype wire

// ==== timer_capture_config_control_asserts.sv ====
// Assertions on the ports of the timer and capture configuration block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tcc_checker
  import timer_capture_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic shared_timer_ext_clock_pin_in,
  input wire logic first_capture_pin_in,
  input wire logic second_capture_pin_in,
  input wire logic first_timer_carry_in,
  input wire logic first_timer_tick_out,
  input wire logic second_timer_tick_out,
  input wire logic timer_pair_cascade_out,
  input wire logic first_capture_event_out,
  input wire logic second_capture_event_out
);
  // Mirror of the configuration register, so outputs can be tied to what software wrote.
  logic [7:0] m_q;
  always_ff @(posedge clk_sys_in)
    if (srst_in)
      m_q <= CFG_RESET;
    else if (reg_wr_in && reg_addr_in == CFG_ADDR)
      m_q <= reg_wdata_in;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  property p_rd_cfg;
    (reg_rd_in && reg_addr_in == CFG_ADDR) |=> reg_rdata_out == m_q;
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("config read data wrong");
  property p_rd_zero;
    (!reg_rd_in || reg_addr_in != CFG_ADDR) |=> reg_rdata_out == READ_ZERO;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("idle read data not zero");
  property p_casc;
    timer_pair_cascade_out == $past(m_q[CASCADE_BIT]);
  endproperty
  a_casc: assert property (p_casc) else $error("cascade level wrong");
  property p_t2_casc;
    timer_pair_cascade_out |->
      second_timer_tick_out == (first_timer_tick_out && $past(first_timer_carry_in));
  endproperty
  a_t2_casc: assert property (p_t2_casc) else $error("upper byte tick wrong");
  property p_t2_sep;
    (!timer_pair_cascade_out && $past(m_q[0]) == $past(m_q[1])) |->
      second_timer_tick_out == first_timer_tick_out;
  endproperty
  a_t2_sep: assert property (p_t2_sep) else $error("separate ticks differ");
  property p_t1_pin;
    ($fell(shared_timer_ext_clock_pin_in) && m_q[0]) ##1 m_q[0] [*2] |=> first_timer_tick_out;
  endproperty
  a_t1_pin: assert property (p_t1_pin) else $error("pin tick missing");
  property p_cap1;
    ($fell(first_capture_pin_in) && m_q[5:4] == CAP_FALLING)
      ##1 (m_q[5:4] == CAP_FALLING) [*3] |=> first_capture_event_out;
  endproperty
  a_cap1: assert property (p_cap1) else $error("falling capture missing");
  property p_cap2;
    ($rose(second_capture_pin_in) && m_q[7:6] == CAP_RISING)
      ##1 (m_q[7:6] == CAP_RISING) [*3] |=> second_capture_event_out;
  endproperty
  a_cap2: assert property (p_cap2) else $error("rising capture missing");
endmodule
bind timer_capture_config_control tcc_checker chk_i (.*);
`default_nettype wire

// ==== timer_capture_config_control_test.sv ====
// Self-checking bench for the timer and capture configuration block.
// Assumes the pin source model drives all four external pins.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_config_control_test;
  import timer_capture_pkg::*;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic carry = 1'b0;
  logic [15:0] count = 16'h1234;
  logic [3:0] go = 4'h0;
  logic [7:0] npulse = 8'h00;
  logic [7:0] half = 8'h03;
  logic [3:0] pins;
  logic [7:0] rdata;
  wire [4:0] tick;
  logic [15:0] val1;
  logic [15:0] val2;
  logic [15:0] cnt [5];
  logic [15:0] cap_exp [4] = '{16'h10, 16'h10, 16'h4, 16'h1};
  int fails = 0;
  int checks = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  timer_capture_config_control dut (.clk_sys_in, .srst_in, .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .shared_timer_ext_clock_pin_in(pins[0]), .third_timer_ext_clock_pin_in(pins[1]),
    .first_capture_pin_in(pins[2]), .second_capture_pin_in(pins[3]),
    .first_timer_carry_in(carry), .third_timer_count_in(count),
    .first_timer_tick_out(tick[0]), .second_timer_tick_out(tick[1]),
    .third_timer_tick_out(tick[2]), .timer_pair_cascade_out(),
    .first_capture_event_out(tick[3]), .second_capture_event_out(tick[4]),
    .first_capture_value_out(val1), .second_capture_value_out(val2));
  pin_source_model src (.clk_sys_in, .go_in(go), .count_in(npulse), .half_in(half),
    .pins_out(pins));
  always @(posedge clk_sys_in)
    foreach (cnt[i]) cnt[i] += {15'h0, tick[i]};
  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, e});
  endtask
  // Counting starts from zero and runs cyc plus two edges.
  task automatic run(input logic [3:0] lanes, input logic [7:0] n, input int cyc);
    @(posedge clk_sys_in);
    #1 foreach (cnt[i]) cnt[i] = 16'h0;
    @(posedge clk_sys_in);
    go <= lanes;
    npulse <= n;
    @(posedge clk_sys_in);
    go <= 4'h0;
    repeat (cyc) @(posedge clk_sys_in);
    #1;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    rd_chk(CFG_ADDR, CFG_RESET);
    wr_reg(CFG_ADDR, 8'h5a);
    rd_chk(CFG_ADDR, 8'h5a);
    wr_reg(CFG_ADDR, 8'ha5);
    wr_reg(8'h17, 8'h00);
    rd_chk(CFG_ADDR, 8'ha5);
    rd_chk(8'h17, READ_ZERO);
    @(posedge clk_sys_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    rd_chk(CFG_ADDR, CFG_RESET);
    $display("test registers done");
    run(4'h0, 8'h00, 38);
    chk(cnt[0], 16'ha);
    chk(cnt[1], 16'ha);
    chk(cnt[2], 16'ha);
    wr_reg(CFG_ADDR, 8'h07);
    run(4'h1, 8'h05, 50);
    chk(cnt[0], 16'h5);
    chk(cnt[1], 16'h5);
    chk(cnt[2], 16'h0);
    @(posedge clk_sys_in);
    half <= 8'h06;
    run(4'h2, 8'h03, 50);
    chk(cnt[2], 16'h3);
    @(posedge clk_sys_in);
    half <= 8'h03;
    carry <= 1'b1;
    wr_reg(CFG_ADDR, 8'h09);
    run(4'h1, 8'h05, 50);
    chk(cnt[1], 16'h5);
    @(posedge clk_sys_in);
    carry <= 1'b0;
    run(4'h1, 8'h05, 50);
    chk(cnt[1], 16'h0);
    wr_reg(CFG_ADDR, 8'h01);
    run(4'h1, 8'h05, 38);
    chk(cnt[1], 16'ha);
    chk(cnt[0], 16'h5);
    $display("test timers done");
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(CFG_ADDR, {2'(i), 2'(i), 4'h0});
      run(4'hc, 8'h10, 110);
      chk(cnt[3], cap_exp[i]);
      chk(cnt[4], cap_exp[i]);
    end
    chk(val1, count);
    chk(val2, count);
    $display("test captures done");
    end_sim;
  end
  initial
  begin
    repeat (3000) @(posedge clk_sys_in);
    fails++;
    end_sim;
  end
endmodule
`default_nettype wire

// ==== timer_capture_pkg.sv ====
// Constants shared by the timer and capture configuration block and its capture edge unit.
// Assumes one 25 MHz system clock and a plain register port with one-cycle strobes.
package timer_capture_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned INSTR_CLK_HZ = CLK_HZ / 4;
  localparam int unsigned INSTR_DIV = CLK_HZ / INSTR_CLK_HZ;
  localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_DIV - 1);

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned TIMER_W = 16;
  localparam logic [ADDR_W-1:0] CFG_ADDR = 8'h16;
  localparam logic [DATA_W-1:0] CFG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  localparam int unsigned FIRST_SRC_BIT = 0;
  localparam int unsigned SECOND_SRC_BIT = 1;
  localparam int unsigned THIRD_SRC_BIT = 2;
  localparam int unsigned CASCADE_BIT = 3;
  localparam int unsigned FIRST_CAP_MODE_LSB = 4;
  localparam int unsigned SECOND_CAP_MODE_LSB = 6;

  localparam logic [1:0] CAP_FALLING = 2'h0;
  localparam logic [1:0] CAP_RISING = 2'h1;
  localparam logic [1:0] CAP_RISING_4 = 2'h2;
  localparam logic [1:0] CAP_RISING_16 = 2'h3;

  localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
  localparam logic [3:0] PRESCALE_16_LAST = 4'hf;

  localparam int unsigned PIN_SHARED = 0;
  localparam int unsigned PIN_THIRD = 1;
  localparam int unsigned PIN_CAP_BASE = 2;
  localparam int unsigned PIN_COUNT = 4;
  localparam int unsigned SYNC_MID = 1;
  localparam int unsigned SYNC_LAST = 2;

endpackage
